/* shared/sgs_map.vh */
// What this block does
// - One-wire scheme: coil input high gives group one, its fall to low gives group two.
// - Selected group stays active until another group is requested or a held group one request drops.
// - Group two primary: returns to group two when held group one request drops.
// - Every status change of each monitored condition emits a time-stamped event unless overwritten while pending.
// - Per-event filter stores assertion edge, deassertion edge, or both.
// - Request for a group not configured raises failure event, on and off.
// - Forced request for a group not configured raises force-failure event, on and off.
// - Remote or signal-input request rejected by held higher-priority request raises failure event, on and off.
// - Remote change request assertion and release reported as separate events.
// - Local change request assertion and release reported as separate events.
// - Group one highest priority; held request blocks all lower requests.
// - Remote change cannot activate group below one requested by a signal input.
`ifndef SGS_MAP_VH
`define SGS_MAP_VH
`define SGS_NGRP        8
`define SGS_NEVT        40
`define SGS_EVT_ENA     0
`define SGS_EVT_REQ     7
`define SGS_EVT_ACT     15
`define SGS_EVT_REMOTE  23
`define SGS_EVT_LOCAL   24
`define SGS_EVT_FORCE   25
`define SGS_EVT_NOCFG   26
`define SGS_EVT_FFAIL   27
`define SGS_EVT_PRIO    28
`define SGS_EVT_W       6
`define SGS_TS_W        32
`define SGS_ACT_RST     8'h01
`define SGS_USED_RST    8'h01
`define SGS_FLT_ON      2'h1
`define SGS_FLT_OFF     2'h2
`define SGS_FLT_BOTH    2'h3
`endif

/* src/sgs_edge_event.v */
`timescale 1ns/1ps
`default_nettype none
`include "sgs_map.vh"
module sgs_edge_event
(
    input  wire       ref_clk,
    input  wire       rst_b,
    input  wire       cond,
    input  wire [1:0] filter,
    output reg        evtValid,
    output reg        evtOn
);
    reg condQ;
    // First edge after reset only learns the level, so no false edge
    reg armed_q;
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            condQ    <= 1'b0;
            armed_q  <= 1'b0;
            evtValid <= 1'b0;
            evtOn    <= 1'b0;
        end
        else
        begin
            condQ   <= cond;
            armed_q <= 1'b1;
            evtValid <= armed_q & ((cond & ~condQ & filter[0]) | (~cond & condQ & filter[1]));
            evtOn    <= cond;
        end
    end
endmodule // sgs_edge_event
`default_nettype wire

/* src/sgs_selector.v */
`timescale 1ns/1ps
`default_nettype none
`include "sgs_map.vh"
module sgs_selector
(
    input  wire                   ref_clk,
    input  wire                   rst_b,
    input  wire [7:0]             groupReq,
    input  wire [7:0]             usedGroups,
    input  wire                   forceEnable,
    input  wire [3:0]             forceGroup,
    input  wire [3:0]             remoteGroup,
    input  wire [3:0]             localGroup,
    input  wire [79:0]            eventFilter,
    output reg  [7:0]             activeGroup,
    output reg                    evtValid,
    output reg  [5:0]             evtId,
    output reg                    evtOn,
    output reg  [31:0]            evtStamp
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    reg [7:0]  reqS1_q, reqS2_q;
    reg        forceS1_q, forceS2_q;
    reg [3:0]  forceGS1_q, forceGS2_q;
    reg [3:0]  remS1_q, remS2_q;
    reg [3:0]  locS1_q, locS2_q;
    reg [7:0]  usedS1_q, usedS2_q;
    reg [7:0]  reqPrev_q;
    reg [3:0]  remPrev_q, locPrev_q, forceGPrev_q;
    reg [31:0] stamp_q;
    reg [7:0]  act_d;
    reg        failNoCfg_q, failForce_q, failPrio_q;
    reg        failNoCfg_d, failForce_d, failPrio_d;
    reg [7:0]  cmdMask;
    reg [7:0]  heldHigh;
    integer    i;

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reqS1_q <= 8'h00; reqS2_q <= 8'h00;
            forceS1_q <= 1'b0; forceS2_q <= 1'b0;
            forceGS1_q <= 4'h0; forceGS2_q <= 4'h0;
            remS1_q <= 4'h0; remS2_q <= 4'h0;
            locS1_q <= 4'h0; locS2_q <= 4'h0;
            usedS1_q <= `SGS_USED_RST; usedS2_q <= `SGS_USED_RST;
        end
        else
        begin
            reqS1_q <= groupReq;   reqS2_q <= reqS1_q;
            forceS1_q <= forceEnable; forceS2_q <= forceS1_q;
            forceGS1_q <= forceGroup; forceGS2_q <= forceGS1_q;
            remS1_q <= remoteGroup; remS2_q <= remS1_q;
            locS1_q <= localGroup;  locS2_q <= locS1_q;
            usedS1_q <= usedGroups; usedS2_q <= usedS1_q;
        end
    end

    // ------------------------------------------------------------
    // Group resolution
    // ------------------------------------------------------------
    function [7:0] dec;
        input [3:0] g;
        begin
            dec = (g >= 4'h1 && g <= 4'h8) ? (8'h01 << (g - 4'h1)) : 8'h00;
        end
    endfunction

    wire [7:0] reqRise = reqS2_q & ~reqPrev_q;
    wire [7:0] remNew  = (remS2_q != remPrev_q) ? dec(remS2_q) : 8'h00;
    wire [7:0] locNew  = (locS2_q != locPrev_q) ? dec(locS2_q) : 8'h00;
    wire [7:0] frcNew  = (forceGS2_q != forceGPrev_q) ? dec(forceGS2_q) : 8'h00;

    always @*
    begin
        act_d       = activeGroup;
        failNoCfg_d = 1'b0;
        failForce_d = 1'b0;
        failPrio_d  = 1'b0;
        cmdMask     = 8'h00;
        heldHigh    = 8'h00;
        // Mask of groups lower than the highest held request
        for (i = 1; i < 8; i = i + 1)
            heldHigh[i] = heldHigh[i-1] | reqS2_q[i-1];
        if (forceS2_q && frcNew != 8'h00)
        begin
            if ((frcNew & usedS2_q) == 8'h00)
                failForce_d = 1'b1;
            else
                cmdMask = frcNew;
        end
        else if (!forceS2_q && locNew != 8'h00)
            cmdMask = locNew;
        else if (remNew != 8'h00)
        begin
            if ((remNew & heldHigh) != 8'h00)
                failPrio_d = 1'b1;
            else
                cmdMask = remNew;
        end
        if (reqS2_q != 8'h00)
        begin
            cmdMask = reqS2_q & ~heldHigh;
            if ((reqRise & heldHigh) != 8'h00)
                failPrio_d = 1'b1;
        end
        else if (reqPrev_q[0] && usedS2_q[1])
            cmdMask = 8'h02;
        if (cmdMask != 8'h00 && (cmdMask & usedS2_q) == 8'h00)
            failNoCfg_d = 1'b1;
        else if (cmdMask != 8'h00)
            act_d = cmdMask;
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            activeGroup  <= `SGS_ACT_RST;
            reqPrev_q    <= 8'h00;
            remPrev_q    <= 4'h0;
            locPrev_q    <= 4'h0;
            forceGPrev_q <= 4'h0;
            failNoCfg_q  <= 1'b0;
            failForce_q  <= 1'b0;
            failPrio_q   <= 1'b0;
            stamp_q      <= 32'h00000000;
        end
        else
        begin
            activeGroup  <= act_d;
            reqPrev_q    <= reqS2_q;
            remPrev_q    <= remS2_q;
            locPrev_q    <= locS2_q;
            forceGPrev_q <= forceGS2_q;
            failNoCfg_q  <= failNoCfg_d;
            failForce_q  <= failForce_d;
            failPrio_q   <= failPrio_d;
            stamp_q      <= stamp_q + 32'h00000001;
        end
    end

    // ------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------
    wire [39:0] conds;
    wire [39:0] evV, evO;
    assign conds[6:0]   = usedS2_q[7:1];
    assign conds[14:7]  = reqS2_q;
    assign conds[22:15] = activeGroup;
    assign conds[23] = remS2_q != 4'h0;
    assign conds[24] = locS2_q != 4'h0;
    assign conds[25] = forceS2_q;
    assign conds[26] = failNoCfg_q;
    assign conds[27] = failForce_q;
    assign conds[28] = failPrio_q;
    assign conds[39:29] = 11'h000;

    genvar g;
    generate
        for (g = 0; g < `SGS_NEVT; g = g + 1)
        begin : gEvt
            sgs_edge_event uEdge
            (
                .ref_clk  (ref_clk),
                .rst_b    (rst_b),
                .cond     (conds[g]),
                .filter   (eventFilter[2*g+1:2*g]),
                .evtValid (evV[g]),
                .evtOn    (evO[g])
            );
        end
    endgenerate

    // pending events, lowest index first, time-stamped
    reg  [39:0] pend_q;
    reg  [39:0] pendOn_q;
    wire [39:0] pendAll  = pend_q | evV;
    wire [39:0] grant    = pendAll & (~pendAll + 40'h0000000001);
    // If granted, the older pending edge goes out and a new edge on it waits; otherwise the new edge replaces it
    wire [39:0] pendNext = (pendAll & ~grant) | (evV & pend_q);
    wire [39:0] onNext   = (pendOn_q & ~evV) | (evO & evV);
    reg        selV;
    reg [5:0]  selId;
    reg        selOn;
    integer    j;
    always @*
    begin
        selV  = 1'b0;
        selId = 6'h00;
        selOn = 1'b0;
        for (j = 0; j < `SGS_NEVT; j = j + 1)
            if (grant[j])
            begin
                selV  = 1'b1;
                selId = j[5:0];
                selOn = pend_q[j] ? pendOn_q[j] : evO[j];
            end
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            evtValid <= 1'b0;
            evtId    <= 6'h00;
            evtOn    <= 1'b0;
            evtStamp <= 32'h00000000;
            pend_q   <= 40'h0000000000;
            pendOn_q <= 40'h0000000000;
        end
        else
        begin
            pend_q   <= pendNext;
            pendOn_q <= onNext;
            evtValid <= selV;
            evtId    <= selId;
            evtOn    <= selOn;
            evtStamp <= stamp_q;
        end
    end
endmodule // sgs_selector
`default_nettype wire

/* dv/sgs_field_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sgs_field_model
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       coilOn,
    input  wire logic       wireOk,
    input  wire logic [7:1] appReq,
    input  wire logic       forceOn,
    input  wire logic [3:0] forceCmd,
    output logic [7:0]      groupReq,
    output logic            forceEnable,
    output logic [3:0]      forceGroup
);
    logic       forceEn_q;
    logic [3:0] forceGrp_q;
    assign groupReq = {appReq, coilOn & wireOk};
    assign forceEnable = forceEn_q;
    assign forceGroup = forceGrp_q;
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            forceEn_q <= 1'b0;
            forceGrp_q <= 4'h0;
        end
        else
        begin
            forceEn_q <= forceOn;
            forceGrp_q <= forceEn_q ? forceCmd : 4'h0;
        end
    end
endmodule // sgs_field_model
`default_nettype wire

/* dv/sgs_selector_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module sgs_selector_checker
(
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic [7:0]  groupReq,
    input wire logic [7:0]  usedGroups,
    input wire logic        forceEnable,
    input wire logic [3:0]  forceGroup,
    input wire logic [3:0]  remoteGroup,
    input wire logic [3:0]  localGroup,
    input wire logic [79:0] eventFilter,
    input wire logic [7:0]  activeGroup,
    input wire logic        evtValid,
    input wire logic [5:0]  evtId,
    input wire logic        evtOn,
    input wire logic [31:0] evtStamp
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    chk_one_active: assert property ($onehot(activeGroup))
        else $error("active group not one-hot");
    chk_held_one: assert property (groupReq[0] [*4] |-> activeGroup == 8'h01)
        else $error("held group one not active");
    chk_fall_two: assert property ($fell(groupReq[0]) && groupReq == 8'h00
        && usedGroups[1] |-> ##3 activeGroup == 8'h02)
        else $error("no return to group two");
    chk_hold_group: assert property (($stable(groupReq) && $stable(remoteGroup) && $stable(localGroup)
        && $stable(forceGroup) && $stable(forceEnable) && $stable(usedGroups)) [*6] |-> $stable(activeGroup))
        else $error("active group moved without cause");
    chk_stamp_step: assert property (evtValid ##1 evtValid |-> evtStamp == $past(evtStamp) + 32'h1)
        else $error("stamp step wrong");
    chk_filter_on: assert property (evtValid && evtOn |-> eventFilter[{evtId, 1'b0}])
        else $error("filtered on event emitted");
    chk_filter_off: assert property (evtValid && !evtOn |-> eventFilter[{evtId, 1'b1}])
        else $error("filtered off event emitted");
    chk_id_range: assert property (evtValid |-> evtId <= 6'h1C)
        else $error("event id out of range");
endmodule // sgs_selector_checker
`default_nettype wire

/* dv/sgs_selector_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sgs_selector_tb;
    logic ref_clk = 1'b0, rst_b = 1'b0, coilOn = 1'b0, wireOk = 1'b1, forceOn = 1'b0;
    logic [7:1] appReq = 7'h00;
    logic [3:0] forceCmd = 4'h0, remoteGroup = 4'h0, localGroup = 4'h0;
    logic [7:0] usedGroups = 8'h0F;
    logic [79:0] eventFilter = 80'hFFFFFFFE7FFFFFFFFFFF;
    wire logic [7:0] groupReq, activeGroup;
    wire logic forceEnable, evtValid, evtOn;
    wire logic [3:0] forceGroup;
    wire logic [5:0] evtId;
    wire logic [31:0] evtStamp;
    int fails = 0, n_checks = 0;
    logic [2:0] a;
    always #12.5 ref_clk = ~ref_clk;
    sgs_field_model u_sgs_field_model (.ref_clk(ref_clk), .rst_b(rst_b), .coilOn(coilOn), .wireOk(wireOk),
        .appReq(appReq), .forceOn(forceOn), .forceCmd(forceCmd), .groupReq(groupReq),
        .forceEnable(forceEnable), .forceGroup(forceGroup));
    sgs_selector u_sgs_selector (.ref_clk(ref_clk), .rst_b(rst_b), .groupReq(groupReq), .usedGroups(usedGroups),
        .forceEnable(forceEnable), .forceGroup(forceGroup), .remoteGroup(remoteGroup), .localGroup(localGroup),
        .eventFilter(eventFilter), .activeGroup(activeGroup), .evtValid(evtValid), .evtId(evtId),
        .evtOn(evtOn), .evtStamp(evtStamp));
    function automatic logic [7:0] exp_grp(input logic [7:0] req);
        return req & (~req + 8'h01);
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic coil(input logic c, input logic w);
        @(posedge ref_clk);
        coilOn <= c;
        wireOk <= w;
        step(6);
    endtask
    task automatic chk_grp(input logic [7:0] exp);
        n_checks++;
        if (activeGroup !== exp)
        begin
            fails++;
            $display("unexpected group at %0t: %0h vs %0h", $time, activeGroup, exp);
        end
    endtask
    task automatic chk_evt(input logic [5:0] id, input logic on);
        logic seen;
        seen = 1'b0;
        repeat (12)
        begin
            @(posedge ref_clk);
            #1;
            if (evtValid === 1'b1 && evtId === id && evtOn === on)
                seen = 1'b1;
        end
        n_checks++;
        if (seen !== 1'b1)
        begin
            fails++;
            $display("unexpected event at %0t: %0h vs %0h", $time, {evtOn, evtId}, {on, id});
        end
    endtask
    task automatic give_verdict;
        if (fails == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (4000) @(posedge ref_clk);
        fails++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(85));
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        step(1);
        chk_grp(8'h01);
        coil(1'b1, 1'b1);
        chk_grp(8'h01);
        coil(1'b0, 1'b1);
        chk_grp(8'h02);
        coil(1'b1, 1'b1);
        coil(1'b1, 1'b0);
        chk_grp(8'h02);
        coil(1'b0, 1'b1);
        @(posedge ref_clk);
        appReq <= 7'h02;
        chk_evt(6'h11, 1'b1);
        @(posedge ref_clk);
        appReq <= 7'h00;
        step(20);
        chk_grp(8'h04);
        coil(1'b1, 1'b1);
        @(posedge ref_clk);
        remoteGroup <= 4'h3;
        chk_evt(6'h17, 1'b1);
        chk_grp(8'h01);
        @(posedge ref_clk);
        appReq <= 7'h02;
        chk_evt(6'h1C, 1'b1);
        chk_grp(8'h01);
        @(posedge ref_clk);
        remoteGroup <= 4'h0;
        appReq <= 7'h00;
        coil(1'b0, 1'b1);
        @(posedge ref_clk);
        localGroup <= 4'h4;
        step(6);
        chk_grp(8'h08);
        @(posedge ref_clk);
        localGroup <= 4'h0;
        chk_evt(6'h18, 1'b0);
        @(posedge ref_clk);
        remoteGroup <= 4'h6;
        chk_evt(6'h1A, 1'b1);
        chk_grp(8'h08);
        @(posedge ref_clk);
        remoteGroup <= 4'h0;
        forceOn <= 1'b1;
        forceCmd <= 4'h7;
        chk_evt(6'h1B, 1'b1);
        @(posedge ref_clk);
        forceCmd <= 4'h3;
        step(6);
        chk_grp(8'h04);
        @(posedge ref_clk);
        localGroup <= 4'h2;
        step(6);
        chk_grp(8'h04);
        @(posedge ref_clk);
        localGroup <= 4'h0;
        forceOn <= 1'b0;
        usedGroups <= 8'h1F;
        chk_evt(6'h03, 1'b1);
        repeat (20)
        begin
            a = 3'($urandom_range(7, 1));
            @(posedge ref_clk);
            appReq <= {4'h0, a};
            step(3);
            @(posedge ref_clk);
            appReq <= 7'h00;
            step(6);
            chk_grp(exp_grp({4'h0, a, 1'b0}));
        end
        give_verdict();
    end
endmodule // sgs_selector_tb
bind sgs_selector sgs_selector_checker u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .groupReq(groupReq),
    .usedGroups(usedGroups), .forceEnable(forceEnable), .forceGroup(forceGroup), .remoteGroup(remoteGroup),
    .localGroup(localGroup), .eventFilter(eventFilter), .activeGroup(activeGroup), .evtValid(evtValid),
    .evtId(evtId), .evtOn(evtOn), .evtStamp(evtStamp));
`default_nettype wire
